// >>> rtl/mailbox_port_defs.svh
/*
  Constants for the two-channel host mailbox port: data width, status bit
  positions, reset values and the least cycles per handshaked word.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef MAILBOX_PORT_DEFS_SVH
`define MAILBOX_PORT_DEFS_SVH
`define MBX_DATA_WIDTH 32
`define MBX_STAT_WCV_BIT 0
`define MBX_STAT_RCV_BIT 1
`define MBX_FLAG_RESET 1'h0
`define MBX_DATA_RESET 32'h0000_0000
`define MBX_CYCLES_PER_WORD 2
`endif

// >>> rtl/mailbox_port_pkg.sv
/*
  Types shared by both ends of the host mailbox port.
  Assumes mailbox_port_defs.svh is on the include path.
*/
`include "mailbox_port_defs.svh"
package mailbox_port_pkg;
  typedef logic [`MBX_DATA_WIDTH-1:0] word_t;
  // Host access selector
  typedef enum logic {SEL_DATA, SEL_STATUS} host_sel_e;
endpackage

// >>> rtl/mailbox_port_if.sv
/*
  Host-side bus between the mailbox port and the host end.
  Assumes one shared clock; the host end resolves the shared acknowledge
  wire from ack_oe (high while the port drives it).
*/
`timescale 1ns/1ps
`default_nettype none
interface mailbox_port_if;
  logic wr_n;
  logic rd_n;
  logic sel;
  mailbox_port_pkg::word_t wdata;
  mailbox_port_pkg::word_t rdata;
  logic host_side_acknowledge;
  logic ack_oe;
  modport port_end (input wr_n, rd_n, sel, wdata, output rdata, host_side_acknowledge, ack_oe);
  modport host_end (output wr_n, rd_n, sel, wdata, input rdata, host_side_acknowledge, ack_oe);
endinterface
`default_nettype wire

// >>> rtl/strobe_rise.sv
/*
  Rising-edge detector for an active-low strobe sampled on the clock.
  Assumes the strobe is synchronous to i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module strobe_rise (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_strobe_n,
  output logic o_rise
);
  logic active_q;
  // Remembers a low strobe; zero after reset like every other flop, and
  // zero also means idle, so no false edge follows reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      active_q <= 1'h0;
    end else begin
      active_q <= ~i_strobe_n;
    end
  end
  assign o_rise = i_strobe_n & active_q;
endmodule
`default_nettype wire

// >>> rtl/mailbox_port.sv
/*
  Device end of the host mailbox port: write latch, read latch, two valid
  flags, status channel, stalling acknowledge and a transfer interrupt.
  Assumes host and processor share i_clock and that all strobes are
  synchronous active-low levels.
*/
// Behaviour
// - Write, read and status channels provided
// - Host write sets write-channel-valid
// - Processor write sets read-channel-valid
// - Reading a channel clears its flag
// - Status read returns both flags
// - Flags change on strobe rising edge
// - Data captured at strobe rise; write channel never overwritten
// - All storage asynchronously reset to zero
// - Acknowledge driven only while host strobe low
// - Write to empty channel acknowledged at once; here one clock after strobe falls
// - Write to full channel stalls until read
// - Read of full channel acknowledged at once; here one clock after strobe falls
// - Read of empty channel stalls until write
// - Each host write raises transfer interrupt
// - Processor flag low when data waiting
// - Host checks pending data before reading
// - Host checks status before each transfer
// - Stale status only delays, never loses
// - Handshaked rate at most one word per two
// - Full rate needs shared clock and memory acknowledge
`timescale 1ns/1ps
`default_nettype none
`include "mailbox_port_defs.svh"
module mailbox_port #(
  parameter int DATA_WIDTH = `MBX_DATA_WIDTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  mailbox_port_if.port_end host,
  input wire logic i_proc_wr_n,
  input wire logic i_proc_rd_n,
  input wire logic [DATA_WIDTH-1:0] i_proc_wdata,
  output logic [DATA_WIDTH-1:0] o_proc_rdata,
  output logic o_processor_flag_input_zero,
  output logic o_transfer_irq,
  output logic o_data_memory_acknowledge
);
  logic write_channel_valid_q;
  logic read_channel_valid_q;
  logic [DATA_WIDTH-1:0] write_latch_q;
  logic [DATA_WIDTH-1:0] read_latch_q;
  logic [DATA_WIDTH-1:0] host_rdata_d;
  logic [DATA_WIDTH-1:0] host_rdata_q;
  logic irq_q;
  logic host_wr_rise;
  logic host_rd_rise;
  logic proc_wr_rise;
  logic proc_rd_rise;
  logic host_data_wr;
  logic host_data_rd;
  logic host_stat_rd;
  logic wr_done_q;
  logic rd_done_q;
  logic [3:0] strobe_n;
  logic [3:0] strobe_up;
  logic host_wr_take;
  logic host_rd_take;
  logic wr_taken_q;
  logic rd_taken_q;

  // Host selector decode, shared by the grant, capture and status paths
  function automatic logic sel_is_data(input logic sel);
    return sel == mailbox_port_pkg::SEL_DATA;
  endfunction

  // Strobe order: host write, host read, processor write, processor read
  assign strobe_n = {i_proc_rd_n, i_proc_wr_n, host.rd_n, host.wr_n};

  // Trailing-edge detectors, one per strobe
  for (genvar i = 0; i < 4; i++) begin : g_rise
    strobe_rise strobe_rise_inst (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_strobe_n(strobe_n[i]),
      .o_rise(strobe_up[i])
    );
  end
  assign host_wr_rise = strobe_up[0];
  assign host_rd_rise = strobe_up[1];
  assign proc_wr_rise = strobe_up[2];
  assign proc_rd_rise = strobe_up[3];

  // A data strobe is taken in every clock that it stands low and granted
  assign host_wr_take = ~host.wr_n & wr_done_q & sel_is_data(host.sel);
  assign host_rd_take = ~host.rd_n & rd_done_q & sel_is_data(host.sel);
  // Only a strobe taken in its last low clock may complete a transfer
  assign host_data_wr = host_wr_rise & wr_taken_q;
  assign host_data_rd = host_rd_rise & rd_taken_q;
  assign host_stat_rd = ~host.rd_n & ~sel_is_data(host.sel);

  // The rise is seen a clock late and the host may move sel with its
  // strobe, so the grant and the selector are kept from the last low clock
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_taken_q <= 1'h0;
      rd_taken_q <= 1'h0;
    end else begin
      wr_taken_q <= host_wr_take;
      rd_taken_q <= host_rd_take;
    end
  end

  // Remember whether the current host cycle found its channel ready; a
  // cycle held off by a full or empty channel finishes only once granted
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      wr_done_q <= 1'h0;
    end else if (host.wr_n) begin
      wr_done_q <= 1'h0;
    end else if (!sel_is_data(host.sel) || !write_channel_valid_q) begin
      wr_done_q <= 1'h1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rd_done_q <= 1'h0;
    end else if (host.rd_n) begin
      rd_done_q <= 1'h0;
    end else if (!sel_is_data(host.sel) || read_channel_valid_q) begin
      rd_done_q <= 1'h1;
    end
  end

  // Write-channel latch follows the host data while a granted strobe stands,
  // so it holds the word present as the strobe rises; a grant needs an empty
  // channel, so an unread word is never overwritten
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      write_latch_q <= `MBX_DATA_RESET;
    end else if (host_wr_take) begin
      write_latch_q <= host.wdata;
    end
  end

  // Read-channel latch follows the processor data while its strobe is low;
  // the flag rises a clock later, so data is always in before the flag
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      read_latch_q <= `MBX_DATA_RESET;
    end else if (!i_proc_wr_n) begin
      read_latch_q <= i_proc_wdata;
    end
  end

  // Write-channel flag; a host write wins over a processor read clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      write_channel_valid_q <= `MBX_FLAG_RESET;
    end else if (host_data_wr) begin
      write_channel_valid_q <= 1'h1;
    end else if (proc_rd_rise) begin
      write_channel_valid_q <= 1'h0;
    end
  end

  // Read-channel flag; a processor write wins over a host read clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      read_channel_valid_q <= `MBX_FLAG_RESET;
    end else if (proc_wr_rise) begin
      read_channel_valid_q <= 1'h1;
    end else if (host_data_rd) begin
      read_channel_valid_q <= 1'h0;
    end
  end

  // Transfer interrupt pulses one cycle per completed host write
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      irq_q <= 1'h0;
    end else begin
      irq_q <= host_data_wr;
    end
  end

  // Host read data: status word or read latch, registered
  always_comb begin
    host_rdata_d = '0;
    if (host_stat_rd) begin
      host_rdata_d[`MBX_STAT_WCV_BIT] = write_channel_valid_q;
      host_rdata_d[`MBX_STAT_RCV_BIT] = read_channel_valid_q;
    end else if (!host.rd_n) begin
      host_rdata_d = read_latch_q;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      host_rdata_q <= `MBX_DATA_RESET;
    end else begin
      host_rdata_q <= host_rdata_d;
    end
  end

  assign host.rdata = host_rdata_q;
  // Acknowledge enabled only during a host strobe; the line is shared
  assign host.ack_oe = ~host.wr_n | ~host.rd_n;
  // Granting takes a cycle, so a word needs two clocks at least
  assign host.host_side_acknowledge = (~host.wr_n & wr_done_q) | (~host.rd_n & rd_done_q);
  assign o_proc_rdata = write_latch_q;
  assign o_processor_flag_input_zero = ~write_channel_valid_q;
  assign o_transfer_irq = irq_q;
  // Memory acknowledge for full-rate use: ready while a host word waits
  assign o_data_memory_acknowledge = write_channel_valid_q;
endmodule
`default_nettype wire

// >>> rtl/mailbox_host.sv
/*
  Host end of the mailbox port: checks status, then runs one data
  transfer per request, holding its strobe until acknowledged.
  Assumes one shared clock with the port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mailbox_port_defs.svh"
module mailbox_host #(
  parameter int DATA_WIDTH = `MBX_DATA_WIDTH
) (
  input wire logic i_clock,
  input wire logic i_rst,
  mailbox_port_if.host_end bus,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [DATA_WIDTH-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [DATA_WIDTH-1:0] o_rsp_rdata
);
  typedef enum logic [2:0] {ST_IDLE, ST_STAT, ST_CHECK, ST_XFER, ST_DONE} host_state_e;
  host_state_e state_q;
  logic write_q;
  logic [DATA_WIDTH-1:0] wdata_q;
  logic [DATA_WIDTH-1:0] rsp_q;
  logic rsp_valid_q;
  logic acked;

  assign acked = bus.ack_oe & bus.host_side_acknowledge;

  // Status first so no access is left hanging on the acknowledge
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_req_valid) begin
            state_q <= ST_STAT;
          end
        end
        ST_STAT: begin
          if (acked) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // Data sampled now reflects the status read; retry if not ready
          if (write_q ? !bus.rdata[`MBX_STAT_WCV_BIT] : bus.rdata[`MBX_STAT_RCV_BIT]) begin
            state_q <= ST_XFER;
          end else begin
            state_q <= ST_STAT;
          end
        end
        ST_XFER: begin
          if (acked) begin
            state_q <= ST_DONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture the request when taken
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      write_q <= 1'h0;
      wdata_q <= `MBX_DATA_RESET;
    end else if (state_q == ST_IDLE && i_req_valid) begin
      write_q <= i_req_write;
      wdata_q <= i_req_wdata;
    end
  end

  // Read data lands one cycle after the read strobe rises
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rsp_q <= `MBX_DATA_RESET;
      rsp_valid_q <= 1'h0;
    end else begin
      rsp_valid_q <= (state_q == ST_DONE);
      if (state_q == ST_DONE && !write_q) begin
        rsp_q <= bus.rdata;
      end
    end
  end

  assign bus.sel = (state_q == ST_XFER) ? mailbox_port_pkg::SEL_DATA : mailbox_port_pkg::SEL_STATUS;
  assign bus.rd_n = ~(state_q == ST_STAT || (state_q == ST_XFER && !write_q));
  assign bus.wr_n = ~(state_q == ST_XFER && write_q);
  assign bus.wdata = wdata_q;
  assign o_req_ready = (state_q == ST_IDLE);
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_rdata = rsp_q;
endmodule
`default_nettype wire

// >>> bench/mailbox_port_sva.sv
/* Checker for the mailbox host bus and port outputs.
   Assumes one shared clock and sel low for data, high for status. */
`timescale 1ns/1ps
`default_nettype none
module mailbox_port_sva (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sel,
  input wire mailbox_port_pkg::word_t rdata,
  input wire logic host_side_acknowledge,
  input wire logic ack_oe,
  input wire logic o_transfer_irq,
  input wire logic o_processor_flag_input_zero
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // A host data write completed by an acknowledged strobe
  sequence s_wr_done;
    $rose(wr_n) && $past(host_side_acknowledge) && !$past(sel);
  endsequence
  property p_oe; ack_oe == (!wr_n || !rd_n); endproperty
  property p_stat_ack; $fell(rd_n) && sel |=> host_side_acknowledge; endproperty
  property p_stat_bits; !rd_n && sel && host_side_acknowledge |-> rdata[31:2] == 30'h0; endproperty
  property p_ack_holds; !rd_n && host_side_acknowledge |=> rd_n || (host_side_acknowledge && $stable(rdata));
  endproperty
  property p_wr_empty; $fell(wr_n) && !sel && o_processor_flag_input_zero |=> host_side_acknowledge; endproperty
  property p_wr_full; !wr_n && !sel && !$past(o_processor_flag_input_zero) |-> !host_side_acknowledge; endproperty
  property p_irq_edge; $rose(o_transfer_irq) |-> $past(wr_n) && !$past(wr_n, 2); endproperty
  property p_irq_cause; s_wr_done |=> o_transfer_irq ##1 !o_transfer_irq; endproperty
  property p_flag_set; s_wr_done |=> !o_processor_flag_input_zero; endproperty
  property p_reset; $fell(i_rst) |-> o_processor_flag_input_zero && !o_transfer_irq && !ack_oe; endproperty
  a_oe: assert property (p_oe) else $error("ack enable without strobe");
  a_stat_ack: assert property (p_stat_ack) else $error("status read not answered");
  a_stat_bits: assert property (p_stat_bits) else $error("status upper bits set");
  a_ack_holds: assert property (p_ack_holds) else $error("read answer dropped");
  a_wr_empty: assert property (p_wr_empty) else $error("write to empty stalled");
  a_wr_full: assert property (p_wr_full) else $error("write to full acknowledged");
  a_irq_edge: assert property (p_irq_edge) else $error("interrupt not at strobe rise");
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt pulse wrong");
  a_flag_set: assert property (p_flag_set) else $error("write flag not set");
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule
`default_nettype wire

// >>> bench/dual_channel_host_mailbox_port_bench.sv
/* Bench joining the mailbox port to its host end, with a queue model.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dual_channel_host_mailbox_port_bench;
  logic i_clock = 1'h0;
  logic i_rst = 1'h1;
  logic req_valid = 1'h0, req_write = 1'h0, proc_wr_n = 1'h1, proc_rd_n = 1'h1;
  logic req_ready, rsp_valid, flag_n, irq, dm_ack;
  mailbox_port_pkg::word_t req_wdata = 32'h0, proc_wdata = 32'h0, rsp_rdata, proc_rdata, got;
  mailbox_port_pkg::word_t rsp_q[$];
  // Read-channel model: processor words in the order they were written
  mailbox_port_pkg::word_t model_q[$];
  int errors = 0, cmp_count = 0, irq_seen = 0, seed = 32'hDDFC;
  mailbox_port_if bus_if ();
  mailbox_port mailbox_port_inst (.i_clock(i_clock), .i_rst(i_rst), .host(bus_if.port_end),
    .i_proc_wr_n(proc_wr_n), .i_proc_rd_n(proc_rd_n), .i_proc_wdata(proc_wdata), .o_proc_rdata(proc_rdata),
    .o_processor_flag_input_zero(flag_n), .o_transfer_irq(irq), .o_data_memory_acknowledge(dm_ack));
  mailbox_host mailbox_host_inst (.i_clock(i_clock), .i_rst(i_rst), .bus(bus_if.host_end), .i_req_valid(req_valid),
    .i_req_write(req_write), .i_req_wdata(req_wdata), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
    .o_rsp_rdata(rsp_rdata));
  mailbox_port_sva mailbox_port_sva_inst (.i_clock(i_clock), .i_rst(i_rst), .wr_n(bus_if.wr_n),
    .rd_n(bus_if.rd_n), .sel(bus_if.sel), .rdata(bus_if.rdata), .host_side_acknowledge(bus_if.host_side_acknowledge),
    .ack_oe(bus_if.ack_oe), .o_transfer_irq(irq), .o_processor_flag_input_zero(flag_n));
  // Free-running clock
  always #5 i_clock = ~i_clock;
  // Registered pulses are taken at the edge that ends their cycle
  always @(posedge i_clock) begin
    if (rsp_valid === 1'h1) rsp_q.push_back(rsp_rdata);
    if (irq === 1'h1) irq_seen++;
  end
  task automatic finish_test();
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input mailbox_port_pkg::word_t exp, input mailbox_port_pkg::word_t seen);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Sampled at falling edges so registered outputs have settled
  task automatic wait_bit(input int which, input logic v);
    repeat (300) begin
      @(negedge i_clock);
      if ((which ? flag_n : req_ready) === v) return;
    end
    errors++;
    finish_test();
  endtask
  task automatic wait_rsp();
    repeat (300) begin
      @(negedge i_clock);
      if (rsp_q.size() > 0) break;
    end
    if (rsp_q.size() == 0) begin
      errors++;
      finish_test();
    end
    got = rsp_q.pop_front();
  endtask
  // Request stays up until the host end shows ready
  task automatic host_req(input logic wr, input mailbox_port_pkg::word_t d);
    @(posedge i_clock);
    req_valid <= 1'h1;
    req_write <= wr;
    req_wdata <= d;
    wait_bit(0, 1'h1);
    @(posedge i_clock);
    req_valid <= 1'h0;
  endtask
  // Processor strobe; write data is scrambled once the strobe is gone
  task automatic proc_op(input logic wr, input mailbox_port_pkg::word_t d);
    @(posedge i_clock);
    proc_wr_n <= !wr;
    proc_rd_n <= wr;
    proc_wdata <= d;
    if (wr) model_q.push_back(d);
    @(posedge i_clock);
    proc_wr_n <= 1'h1;
    proc_rd_n <= 1'h1;
    proc_wdata <= ~d;
    repeat (3) @(negedge i_clock);
  endtask
  initial begin
    mailbox_port_pkg::word_t w, w2;
    repeat (10) @(posedge i_clock);
    i_rst <= 1'h0;
    @(negedge i_clock);
    chk("flag", 32'h1, flag_n);
    chk("irq", 32'h0, irq);
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      w2 = $random(seed);
      host_req(1'h1, w);
      wait_rsp();
      wait_bit(1, 1'h0);
      chk("proc data", w, proc_rdata);
      chk("flag", 32'h0, flag_n);
      chk("dm ack", 32'h1, dm_ack);
      host_req(1'h1, w2);
      repeat (20) @(negedge i_clock);
      chk("write stall", 32'h0, rsp_q.size());
      chk("kept data", w, proc_rdata);
      proc_op(1'h0, 32'h0);
      wait_rsp();
      wait_bit(1, 1'h0);
      chk("proc data", w2, proc_rdata);
      proc_op(1'h0, 32'h0);
      chk("flag", 32'h1, flag_n);
      host_req(1'h0, 32'h0);
      repeat (20) @(negedge i_clock);
      chk("read stall", 32'h0, rsp_q.size());
      proc_op(1'h1, w);
      wait_rsp();
      chk("model depth", 32'h1, model_q.size());
      chk("host data", model_q.pop_front(), got);
    end
    chk("irq count", 32'h8, irq_seen);
    finish_test();
  end
endmodule
`default_nettype wire
